// ===== design/local_bus_cycle_ctrl.sv
// Local bus cycle controller: request queue, link sequencer, completion
//
// Overview of operation
// - Each cycle opens with the address strobe low for exactly one clock.
// - Address and status are valid at the edge that samples the strobe.
// - Four lane enables name the byte lanes used by the transfer.
// - Burst-last means the next burst-ready ends the transfer.
// - Local-ready with burst-ready: burst-ready ignored, whole transfer ends.
// - Data/code status low while code is transferred.
// - Data/code status high while data is transferred.
// - Memory/io status low for io, high for memory.
// - Write/read status low for read, high for write.
// - All bus timing refers to the rising edge of the processor clock.
`timescale 1ns/1ps
`default_nettype none
module local_bus_cycle_ctrl
	import local_bus_pkg::*;
#(
	parameter int FIFO_DEPTH = REQ_FIFO_DEPTH
) (
	input wire logic clk, // System clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic reqValid, // Cycle request offered
	output logic reqReady, // Request queue has room
	input wire bus_req_t reqData, // Cycle request
	output logic doneValid, // One pulse per finished transfer
	output logic doneByLocalReady, // Last transfer ended by local ready
	input wire logic linkClk, // Local bus clock
	input wire logic burstBeatReady_n, // Target ends a beat
	input wire logic localTransferReady_n, // Target ends the transfer
	output logic cycleStartStrobe_n, // Address strobe
	output logic finalBeatFlag_n, // Next beat ready is the last
	output logic [LANE_W-1:0] laneEnables, // Active byte lanes, high
	output logic [ADDR_W-1:0] busAddress, // Word address
	output logic dataOrCodeStatus, // High data, low code
	output logic memoryOrIoStatus, // High memory, low io
	output logic writeOrReadStatus // High write, low read
);

	typedef struct packed {
		link_phase_t phase;
		bus_req_t cur;
		logic [BEAT_W-1:0] beatsLeft;
		logic strobe_n;
		logic final_n;
		logic doneToggle;
		logic doneLocal;
		logic ackSync1;
		logic ackSync2;
	} link_state_t;

	typedef struct packed {
		logic doneSync1;
		logic doneSync2;
		logic doneSeen;
		logic doneValid;
		logic doneByLocal;
	} sys_state_t;

	localparam link_state_t LINK_RESET = '{
		phase: PH_IDLE,
		cur: REQ_IDLE,
		beatsLeft: BEATS_LAST,
		strobe_n: 1'b1,
		final_n: 1'b1,
		doneToggle: 1'b0,
		doneLocal: 1'b0,
		ackSync1: 1'b0,
		ackSync2: 1'b0
	};

	link_state_t ls;
	link_state_t next_ls;
	sys_state_t ss;
	sys_state_t next_ss;
	logic [SYNC_STAGES-1:0] linkRstPipe;
	logic linkReset_n;
	logic fifoValid;
	logic fifoPop;
	bus_req_t fifoData;
	cycle_status_t curStatus;
	logic beatEnd;
	logic transferEnd;

	// Request queue crosses from the system clock to the bus clock
	cdc_req_fifo #(
		.WIDTH($bits(bus_req_t)),
		.DEPTH(FIFO_DEPTH)
	) reqQueue (
		.wrClk(clk),
		.wrReset_n(reset_n),
		.wrValid(reqValid),
		.wrReady(reqReady),
		.wrData(reqData),
		.rdClk(linkClk),
		.rdReset_n(linkReset_n),
		.rdValid(fifoValid),
		.rdReady(fifoPop),
		.rdData(fifoData)
	);

	// Reset enters the bus domain asynchronously, leaves synchronously
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			linkRstPipe <= SYNC_CLEAR;
		end else begin
			linkRstPipe <= {linkRstPipe[0], SYNC_FILL[0]};
		end
	end
	assign linkReset_n = linkRstPipe[SYNC_STAGES-1];

	assign curStatus = kind_status(ls.cur.kind);
	assign cycleStartStrobe_n = ls.strobe_n;
	assign finalBeatFlag_n = ls.final_n;
	assign laneEnables = ls.cur.lanes;
	assign busAddress = ls.cur.addr;
	assign dataOrCodeStatus = curStatus.dataOrCode;
	assign memoryOrIoStatus = curStatus.memoryOrIo;
	assign writeOrReadStatus = curStatus.writeOrRead;

	// Readies are pins of this same clock, sampled at its rising edge
	assign beatEnd = (ls.phase == PH_DATA) && !burstBeatReady_n;
	assign transferEnd = (ls.phase == PH_DATA)
		&& (!localTransferReady_n
		|| (!burstBeatReady_n && ls.beatsLeft == BEATS_LAST));

	always_comb begin
		next_ls = ls;
		fifoPop = 1'b0;
		next_ls.strobe_n = 1'b1;
		next_ls.ackSync1 = ss.doneSeen;
		next_ls.ackSync2 = ls.ackSync1;
		unique case (ls.phase)
			PH_IDLE: begin
				// Wait until the previous completion was acknowledged
				if (fifoValid && ls.ackSync2 == ls.doneToggle) begin
					fifoPop = 1'b1;
					next_ls.cur = fifoData;
					next_ls.beatsLeft = fifoData.extraBeats;
					next_ls.strobe_n = 1'b0;
					next_ls.final_n = fifoData.extraBeats != BEATS_LAST;
					next_ls.phase = PH_ADDR;
				end
			end
			PH_ADDR: begin
				// Target samples the strobe here; readies not yet valid
				next_ls.phase = PH_DATA;
			end
			PH_DATA: begin
				if (!localTransferReady_n) begin
					// Burst ready in the same clock is ignored
					next_ls.phase = PH_IDLE;
					next_ls.final_n = 1'b1;
					next_ls.doneToggle = !ls.doneToggle;
					next_ls.doneLocal = 1'b1;
				end else if (!burstBeatReady_n) begin
					if (ls.beatsLeft == BEATS_LAST) begin
						next_ls.phase = PH_IDLE;
						next_ls.final_n = 1'b1;
						next_ls.doneToggle = !ls.doneToggle;
						next_ls.doneLocal = 1'b0;
					end else begin
						next_ls.beatsLeft = ls.beatsLeft - BEAT_STEP;
						next_ls.final_n = next_ls.beatsLeft != BEATS_LAST;
					end
				end
			end
			default: begin
				next_ls.phase = PH_IDLE;
			end
		endcase
	end

	// Every bus output changes only on the rising bus clock edge or when reset asserts
	always_ff @(posedge linkClk or negedge linkReset_n) begin
		if (!linkReset_n) begin
			ls <= LINK_RESET;
		end else begin
			ls <= next_ls;
		end
	end

	// Completion toggle crosses back; its held flag is stable by then
	always_comb begin
		next_ss = ss;
		next_ss.doneSync1 = ls.doneToggle;
		next_ss.doneSync2 = ss.doneSync1;
		next_ss.doneValid = 1'b0;
		if (ss.doneSync2 != ss.doneSeen) begin
			next_ss.doneSeen = ss.doneSync2;
			next_ss.doneValid = 1'b1;
			next_ss.doneByLocal = ls.doneLocal;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ss <= '0;
		end else begin
			ss <= next_ss;
		end
	end

	assign doneValid = ss.doneValid;
	assign doneByLocalReady = ss.doneByLocal;

	// Checks on the bus side; the completion pulse and queue-full checks use the system clock
	a_strobe_one_clock: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		$fell(cycleStartStrobe_n) |=> cycleStartStrobe_n
			&& (ls.phase == PH_DATA))
		else $error("address strobe not exactly one clock");

	a_strobe_only_start: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		!cycleStartStrobe_n |-> ls.phase == PH_ADDR
			&& $past(ls.phase) == PH_IDLE)
		else $error("address strobe outside cycle start");

	a_status_at_sample: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		!cycleStartStrobe_n |=> $stable(busAddress)
			&& $stable({memoryOrIoStatus, dataOrCodeStatus,
			writeOrReadStatus}))
		else $error("address or status moved at strobe sample");

	a_lanes_from_req: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop |=> laneEnables == $past(fifoData.lanes))
		else $error("lane enables differ from request");

	a_final_beat_flag: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		(ls.phase == PH_DATA) |->
			(!finalBeatFlag_n == (ls.beatsLeft == BEATS_LAST)))
		else $error("burst last flag wrong for beats left");

	a_beat_counts_down: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		beatEnd && localTransferReady_n && ls.beatsLeft != BEATS_LAST
		|=> ls.phase == PH_DATA
			&& ls.beatsLeft == $past(ls.beatsLeft) - BEAT_STEP)
		else $error("burst ready did not advance the beat");

	a_local_wins: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		(ls.phase == PH_DATA) && !localTransferReady_n
			&& !burstBeatReady_n
		|=> ls.phase == PH_IDLE && ls.doneLocal && finalBeatFlag_n)
		else $error("local ready did not end the transfer");

	a_code_status: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop && fifoData.kind == KIND_CODE_READ
		|=> !dataOrCodeStatus && memoryOrIoStatus && !writeOrReadStatus)
		else $error("code fetch status wrong");

	a_data_status: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop && (fifoData.kind == KIND_MEM_READ
			|| fifoData.kind == KIND_IO_READ)
		|=> dataOrCodeStatus)
		else $error("data transfer status wrong");

	a_mem_io_status: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop && fifoData.kind == KIND_IO_WRITE
		|=> !memoryOrIoStatus && writeOrReadStatus)
		else $error("io write status wrong");

	a_write_status: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop && fifoData.kind == KIND_MEM_WRITE
		|=> memoryOrIoStatus && writeOrReadStatus)
		else $error("memory write status wrong");

	a_outputs_hold: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		(ls.phase == PH_DATA) && !transferEnd
		|=> $stable(ls.cur))
		else $error("cycle outputs changed mid transfer");

	a_strobe_opens_cycle: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		(ls.phase == PH_ADDR) |-> !cycleStartStrobe_n)
		else $error("cycle started without address strobe");

	a_single_beat_flag: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop && fifoData.extraBeats == BEATS_LAST
		|=> !finalBeatFlag_n && !cycleStartStrobe_n)
		else $error("single beat cycle without burst last");

	a_last_beat_ends: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		!finalBeatFlag_n && beatEnd && localTransferReady_n
		|=> (ls.phase == PH_IDLE) && finalBeatFlag_n)
		else $error("burst ready under burst last did not end");

	a_end_goes_idle: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		transferEnd |=> (ls.phase == PH_IDLE) && finalBeatFlag_n)
		else $error("transfer end did not return to idle");

	a_io_read_status: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop && fifoData.kind == KIND_IO_READ
		|=> !memoryOrIoStatus && dataOrCodeStatus && !writeOrReadStatus)
		else $error("io read status wrong");

	a_pins_hold: assert property (
		@(posedge linkClk) disable iff (!linkReset_n)
		(ls.phase == PH_DATA) |-> $stable({busAddress, laneEnables,
			memoryOrIoStatus, dataOrCodeStatus, writeOrReadStatus}))
		else $error("bus pins moved during transfer");

	a_done_reported: assert property (
		@(posedge clk) disable iff (!reset_n)
		$changed(ss.doneSync2) |=> doneValid ##1 !doneValid)
		else $error("completion pulse missing or too long");

	c_single_beat: cover property (
		@(posedge linkClk) disable iff (!linkReset_n)
		fifoPop && fifoData.extraBeats == BEATS_LAST
		##2 transferEnd);

	c_four_beats: cover property (
		@(posedge linkClk) disable iff (!linkReset_n)
		beatEnd && ls.beatsLeft == BEAT_STEP + BEAT_STEP + BEAT_STEP);

	c_local_end: cover property (
		@(posedge linkClk) disable iff (!linkReset_n)
		(ls.phase == PH_DATA) && !localTransferReady_n
			&& !burstBeatReady_n);

	c_queue_full: cover property (
		@(posedge clk) disable iff (!reset_n)
		reqValid && !reqReady);

	c_wait_state: cover property (
		@(posedge linkClk) disable iff (!linkReset_n)
		(ls.phase == PH_DATA) && burstBeatReady_n
			&& localTransferReady_n);

endmodule : local_bus_cycle_ctrl
`default_nettype wire

// ===== include/local_bus_pkg.sv
// Shared types and constants for the local bus cycle controller
package local_bus_pkg;

	localparam int ADDR_W = 30;
	localparam int LANE_W = 4;
	localparam int BEAT_W = 2;
	localparam int REQ_FIFO_DEPTH = 16;
	localparam int SYNC_STAGES = 2;

	localparam logic [BEAT_W-1:0] BEATS_LAST = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
	localparam logic [SYNC_STAGES-1:0] SYNC_CLEAR = 2'h0;
	localparam logic [SYNC_STAGES-1:0] SYNC_FILL = 2'h1;

	// Code bits are {memory/io, data/code, write/read}
	typedef enum logic [2:0] {
		KIND_INT_ACK = 3'h0,
		KIND_HALT = 3'h1,
		KIND_IO_READ = 3'h2,
		KIND_IO_WRITE = 3'h3,
		KIND_CODE_READ = 3'h4,
		KIND_RESERVED = 3'h5,
		KIND_MEM_READ = 3'h6,
		KIND_MEM_WRITE = 3'h7
	} cycle_kind_t;

	typedef struct packed {
		logic memoryOrIo;
		logic dataOrCode;
		logic writeOrRead;
	} cycle_status_t;

	// One queued bus cycle; extraBeats is beats minus one
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANE_W-1:0] lanes;
		cycle_kind_t kind;
		logic [BEAT_W-1:0] extraBeats;
	} bus_req_t;

	localparam bus_req_t REQ_IDLE = '{
		addr: '0,
		lanes: '0,
		kind: KIND_MEM_READ,
		extraBeats: BEATS_LAST
	};

	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_ADDR = 2'h1,
		PH_DATA = 2'h3
	} link_phase_t;

	function automatic cycle_status_t kind_status(cycle_kind_t k);
		return cycle_status_t'(k);
	endfunction : kind_status

endpackage : local_bus_pkg

// ===== design/cdc_req_fifo.sv
// Dual-clock request FIFO with gray-coded pointers
`timescale 1ns/1ps
`default_nettype none
module cdc_req_fifo #(
	parameter int WIDTH = 39,
	parameter int DEPTH = 16
) (
	input wire logic wrClk, // Filling side clock
	input wire logic wrReset_n, // Filling side reset
	input wire logic wrValid, // Word offered
	output logic wrReady, // Room for a word
	input wire logic [WIDTH-1:0] wrData, // Word to store
	input wire logic rdClk, // Draining side clock
	input wire logic rdReset_n, // Draining side reset
	output logic rdValid, // Word available
	input wire logic rdReady, // Word taken
	output logic [WIDTH-1:0] rdData // Oldest word
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] ptrBin;
		logic [AW:0] ptrGray;
		logic [AW:0] farSync1;
		logic [AW:0] farSync2;
		logic ready;
	} wr_state_t;

	typedef struct packed {
		logic [AW:0] ptrBin;
		logic [AW:0] ptrGray;
		logic [AW:0] farSync1;
		logic [AW:0] farSync2;
	} rd_state_t;

	function automatic logic [AW:0] to_gray(logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction : to_gray

	logic [WIDTH-1:0] mem [DEPTH];
	wr_state_t ws;
	wr_state_t next_ws;
	rd_state_t rs;
	rd_state_t next_rs;
	logic push;
	logic [AW:0] fullMark;

	assign push = wrValid && ws.ready;
	assign wrReady = ws.ready;
	assign rdValid = rs.ptrGray != rs.farSync2;
	assign rdData = mem[rs.ptrBin[AW-1:0]];

	always_comb begin
		next_ws = ws;
		next_ws.farSync1 = rs.ptrGray;
		next_ws.farSync2 = ws.farSync1;
		if (push) begin
			next_ws.ptrBin = ws.ptrBin + 1'b1;
			next_ws.ptrGray = to_gray(next_ws.ptrBin);
		end
		// Full when the pointers differ only in their two top bits
		fullMark = {~ws.farSync2[AW:AW-1], ws.farSync2[AW-2:0]};
		next_ws.ready = next_ws.ptrGray != fullMark;
	end

	always_ff @(posedge wrClk or negedge wrReset_n) begin
		if (!wrReset_n) begin
			ws <= '0;
		end else begin
			ws <= next_ws;
		end
	end

	always_ff @(posedge wrClk) begin
		if (push) begin
			mem[ws.ptrBin[AW-1:0]] <= wrData;
		end
	end

	always_comb begin
		next_rs = rs;
		next_rs.farSync1 = ws.ptrGray;
		next_rs.farSync2 = rs.farSync1;
		if (rdValid && rdReady) begin
			next_rs.ptrBin = rs.ptrBin + 1'b1;
			next_rs.ptrGray = to_gray(next_rs.ptrBin);
		end
	end

	always_ff @(posedge rdClk or negedge rdReset_n) begin
		if (!rdReset_n) begin
			rs <= '0;
		end else begin
			rs <= next_rs;
		end
	end

endmodule : cdc_req_fifo
`default_nettype wire

// ===== dv/bus_target_model.sv
// Behavioural local bus target answering host cycles
`timescale 1ns/1ps
`default_nettype none
module bus_target_model
	import local_bus_pkg::*;
(
	input wire logic linkClk, // Local bus clock
	input wire logic reset_n, // Reset, active low
	input wire logic cycleStartStrobe_n, // Address strobe
	input wire logic finalBeatFlag_n, // Last beat marker
	input wire logic [LANE_W-1:0] laneEnables, // Byte lanes
	input wire logic [ADDR_W-1:0] busAddress, // Word address
	input wire logic dataOrCodeStatus, // Data or code
	input wire logic memoryOrIoStatus, // Memory or io
	input wire logic writeOrReadStatus, // Write or read
	input wire logic [7:0] waitCycles, // Wait states per beat
	input wire logic endByLocal, // End with local ready
	output logic burstBeatReady_n, // Beat end
	output logic localTransferReady_n, // Transfer end
	output logic [ADDR_W-1:0] capAddr, // Captured address
	output logic [LANE_W-1:0] capLanes, // Captured lanes
	output logic [2:0] capStatus, // Captured status
	output logic [7:0] beats, // Beats completed
	output logic [7:0] stableErr // Changes mid transfer
);
	logic fin;
	initial begin
		burstBeatReady_n = 1'b1;
		localTransferReady_n = 1'b1;
		stableErr = 8'h00;
		beats = 8'h00;
		forever begin
			@(posedge linkClk);
			// Look once the launching edge has settled
			#1;
			if (reset_n === 1'b1 && cycleStartStrobe_n === 1'b0) begin
				capAddr = busAddress;
				capLanes = laneEnables;
				capStatus = {memoryOrIoStatus, dataOrCodeStatus,
					writeOrReadStatus};
				beats = 8'h00;
				fin = 1'b0;
				// Edge that samples the strobe low
				@(posedge linkClk);
				while (!fin && beats != 8'h10) begin
					repeat (waitCycles) @(posedge linkClk);
					#1;
					burstBeatReady_n = 1'b0;
					localTransferReady_n = !endByLocal;
					fin = endByLocal || finalBeatFlag_n === 1'b0;
					if (busAddress !== capAddr || laneEnables !== capLanes
						|| {memoryOrIoStatus, dataOrCodeStatus,
						writeOrReadStatus} !== capStatus)
						stableErr = stableErr + 8'h01;
					@(posedge linkClk);
					beats = beats + 8'h01;
					#1;
					burstBeatReady_n = 1'b1;
					localTransferReady_n = 1'b1;
				end
			end
		end
	end
endmodule : bus_target_model
`default_nettype wire

// ===== dv/local_bus_host_cycle_control_tb.sv
// Testbench for the local bus cycle controller
`timescale 1ns/1ps
`default_nettype none
module local_bus_host_cycle_control_tb import local_bus_pkg::*;;
	logic clk, linkClk, reset_n, reqValid, reqReady, doneValid;
	logic doneByLocalReady, burstBeatReady_n, localTransferReady_n;
	logic cycleStartStrobe_n, finalBeatFlag_n, endByLocal, sawFull;
	logic dataOrCodeStatus, memoryOrIoStatus, writeOrReadStatus;
	bus_req_t reqData;
	logic [LANE_W-1:0] laneEnables, capLanes;
	logic [ADDR_W-1:0] busAddress, capAddr;
	logic [2:0] capStatus;
	logic [7:0] waitCycles, beats, stableErr;
	int nFail = 0;
	int numChecks = 0;
	int nDone = 0;

	local_bus_cycle_ctrl i_local_bus_cycle_ctrl (.clk(clk), .reset_n(reset_n),
		.reqValid(reqValid), .reqReady(reqReady), .reqData(reqData),
		.doneValid(doneValid), .doneByLocalReady(doneByLocalReady),
		.linkClk(linkClk), .burstBeatReady_n(burstBeatReady_n),
		.localTransferReady_n(localTransferReady_n),
		.cycleStartStrobe_n(cycleStartStrobe_n),
		.finalBeatFlag_n(finalBeatFlag_n), .laneEnables(laneEnables),
		.busAddress(busAddress), .dataOrCodeStatus(dataOrCodeStatus),
		.memoryOrIoStatus(memoryOrIoStatus),
		.writeOrReadStatus(writeOrReadStatus));

	bus_target_model i_bus_target_model (.linkClk(linkClk), .reset_n(reset_n),
		.cycleStartStrobe_n(cycleStartStrobe_n),
		.finalBeatFlag_n(finalBeatFlag_n), .laneEnables(laneEnables),
		.busAddress(busAddress), .dataOrCodeStatus(dataOrCodeStatus),
		.memoryOrIoStatus(memoryOrIoStatus),
		.writeOrReadStatus(writeOrReadStatus), .waitCycles(waitCycles),
		.endByLocal(endByLocal), .burstBeatReady_n(burstBeatReady_n),
		.localTransferReady_n(localTransferReady_n), .capAddr(capAddr),
		.capLanes(capLanes), .capStatus(capStatus), .beats(beats),
		.stableErr(stableErr));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Phase unrelated to the system clock
	initial begin
		linkClk = 1'b0;
		#1.3;
		forever #3 linkClk = ~linkClk;
	end

	always @(posedge clk) begin
		if (doneValid === 1'b1)
			nDone <= nDone + 1;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// Holds reqValid high; caller lowers it
	task automatic send(input logic [29:0] a, input logic [3:0] l,
			input logic [2:0] k, input logic [1:0] x);
		int n;
		reqData = '{addr: a, lanes: l, kind: cycle_kind_t'(k), extraBeats: x};
		reqValid = 1'b1;
		for (n = 0; n < 2000 && reqReady !== 1'b1; n++) begin
			sawFull = 1'b1;
			@(posedge clk);
			#2;
		end
		if (n == 2000) begin
			nFail++;
			complete_run();
		end
		@(posedge clk);
		#2;
	endtask : send

	task automatic wait_done(input int target);
		int n;
		for (n = 0; n < 3000 && nDone < target; n++)
			@(posedge clk);
		if (nDone < target) begin
			nFail++;
			complete_run();
		end
		#2;
	endtask : wait_done

	task automatic run_one(input logic [29:0] a, input logic [3:0] l,
			input logic [2:0] k, input logic [1:0] x, input logic loc,
			input logic [7:0] w);
		int base;
		base = nDone;
		endByLocal = loc;
		waitCycles = w;
		send(a, l, k, x);
		reqValid = 1'b0;
		wait_done(base + 1);
	endtask : run_one

	task automatic test_kinds;
		int k;
		logic [29:0] a;
		for (k = 0; k < 8; k++) begin
			a = 30'h0ABC000 + 30'(k);
			run_one(a, 4'h1 << k[1:0], k[2:0], 2'h0, 1'b0, 8'h00);
			check(32'(capStatus), 32'(k));
			check(32'(capAddr), 32'(a));
			check(32'(capLanes), 32'(4'h1 << k[1:0]));
			check(32'(beats), 32'h1);
		end
		$display("test kinds finished");
	endtask : test_kinds

	task automatic test_burst;
		run_one(30'h3FFFFF0, 4'hC, 3'h7, 2'h3, 1'b0, 8'h02);
		check(32'(beats), 32'h4);
		check(32'(stableErr), 32'h0);
		check(32'(doneByLocalReady), 32'h0);
		check(32'(capStatus), 32'h7);
		$display("test burst finished");
	endtask : test_burst

	task automatic test_local;
		run_one(30'h0000011, 4'hF, 3'h6, 2'h3, 1'b1, 8'h01);
		check(32'(beats), 32'h1);
		check(32'(doneByLocalReady), 32'h1);
		$display("test local finished");
	endtask : test_local

	task automatic test_fill;
		int i;
		int base;
		base = nDone;
		sawFull = 1'b0;
		waitCycles = 8'h1E;
		endByLocal = 1'b0;
		for (i = 0; i < 20; i++)
			send(30'h0000100 + 30'(i), 4'hF, 3'h6, 2'h0);
		reqValid = 1'b0;
		check(32'(sawFull), 32'h1);
		wait_done(base + 20);
		check(32'(nDone - base), 32'd20);
		$display("test fill finished");
	endtask : test_fill

	initial begin
		reset_n = 1'b0;
		reqValid = 1'b0;
		reqData = REQ_IDLE;
		waitCycles = 8'h00;
		endByLocal = 1'b0;
		sawFull = 1'b0;
		repeat (5) @(posedge clk);
		#2;
		reset_n = 1'b1;
		repeat (3) @(posedge clk);
		#2;
		test_kinds();
		test_burst();
		test_local();
		test_fill();
		complete_run();
	end
endmodule : local_bus_host_cycle_control_tb
`default_nettype wire
